// ==== ievt_pkg.sv ====
package ievt_pkg;

	// register byte offsets on the AXI4-Lite port
	localparam logic [4:0] OFS_PRESCALER_MODE   = 5'h00;
	localparam logic [4:0] OFS_MODE_CONTROL     = 5'h04;
	localparam logic [4:0] OFS_CAPTURE_CONTROL  = 5'h08;
	localparam logic [4:0] OFS_COMPARE_CAPTURE  = 5'h0C;
	localparam logic [4:0] OFS_CAPTURE_B        = 5'h10;
	localparam logic [4:0] OFS_COUNT_REGISTER   = 5'h14;
	localparam logic [4:0] OFS_STATUS           = 5'h18;

	// prescaler_mode fields
	localparam int CLOCK_SELECT_BIT_LOW  = 0;
	localparam int EDGE_SELECT_A_LOW     = 4;
	localparam int EDGE_SELECT_B_LOW     = 6;
	// mode_control_reg field
	localparam int MODE_FIELD_LOW        = 0;
	// capture_compare_control field
	localparam int DUAL_CAPTURE_BIT      = 0;
	// status fields
	localparam int STATUS_OVERFLOW_BIT   = 0;
	localparam int STATUS_MATCH_BIT      = 1;
	localparam int STATUS_CAPTURE_BIT    = 2;

	// reset values and the counter maximum
	localparam logic [7:0]  PRESCALER_MODE_RESET  = 8'h00;
	localparam logic [1:0]  MODE_CONTROL_RESET    = 2'h0;
	localparam logic        CAPTURE_CONTROL_RESET = 1'h0;
	localparam logic [15:0] COMPARE_CAPTURE_RESET = 16'h0000;
	localparam logic [15:0] CAPTURE_B_RESET       = 16'h0000;
	localparam logic [15:0] COUNT_RESET           = 16'h0000;
	localparam logic [15:0] COUNT_MAX             = 16'hFFFF;

	// prescaler divide masks (divide by 4 and by 256)
	localparam logic [7:0] DIV4_MASK   = 8'h03;
	localparam logic [7:0] DIV256_MASK = 8'hFF;

	// count clock choices
	localparam logic [1:0] CLK_PERIPH    = 2'h0;
	localparam logic [1:0] CLK_DIV4      = 2'h1;
	localparam logic [1:0] CLK_DIV256    = 2'h2;
	localparam logic [1:0] CLK_EVENT_PIN = 2'h3;

	// edge selections
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// mode field codes
	localparam logic [1:0] MODE_STOP  = 2'h0;
	localparam logic [1:0] MODE_FREE  = 2'h1;
	localparam logic [1:0] MODE_CLEAR = 2'h2;

	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		RUN_STOP  = 3'b001,
		RUN_FREE  = 3'b010,
		RUN_CLEAR = 3'b100
	} ievt_run_t;

	typedef struct packed {
		logic [31:0] awaddr;
		logic        awvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        wvalid;
		logic        bready;
		logic [31:0] araddr;
		logic        arvalid;
		logic        rready;
	} ievt_axil_req_t;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} ievt_axil_rsp_t;

endpackage : ievt_pkg

// ==== ievt_edge_filter.sv ====
`timescale 1ns/1ps

// double-sampling edge detector: a level counts only once seen on two samples
module ievt_edge_filter (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       clock_enable,
	// sampling and selection
	input  wire logic       sample,
	input  wire logic       level,
	input  wire logic [1:0] edge_sel,
	// detected edge, one cycle
	output logic            edge_hit
);

	logic first;
	logic second;
	logic stable;
	logic next_first;
	logic next_second;
	logic next_stable;
	logic next_edge_hit;

	// glitch shorter than one sample period never reaches the stable level
	always_comb begin
		next_first    = first;
		next_second   = second;
		next_stable   = stable;
		next_edge_hit = 1'b0;
		if (sample) begin
			next_first  = level;
			next_second = first;
			if ((first == second) && (second != stable)) begin
				next_stable = second;
				unique case (edge_sel)
					ievt_pkg::EDGE_FALL: next_edge_hit = !second;
					ievt_pkg::EDGE_RISE: next_edge_hit = second;
					ievt_pkg::EDGE_BOTH: next_edge_hit = 1'b1;
					default:             next_edge_hit = 1'b0; // prohibited code
				endcase
			end
		end
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			first    <= 1'b0;
			second   <= 1'b0;
			stable   <= 1'b0;
			edge_hit <= 1'b0;
		end else if (clock_enable) begin
			first    <= next_first;
			second   <= next_second;
			stable   <= next_stable;
			edge_hit <= next_edge_hit;
		end
	end

endmodule : ievt_edge_filter

// ==== ievt_timer.sv ====
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps

module ievt_timer (
	// clock and reset
	input  wire logic                     clock,
	input  wire logic                     reset,
	input  wire logic                     clock_enable,
	// register bus
	input  wire ievt_pkg::ievt_axil_req_t axil_req,
	output ievt_pkg::ievt_axil_rsp_t      axil_rsp,
	// input pins
	input  wire logic                     event_input_a,
	input  wire logic                     capture_input_b,
	// event outputs, one cycle each
	output logic                          match_irq_a,
	output logic                          capture_irq_b
);

	// software registers
	logic [7:0]          prescaler_mode;
	logic [1:0]          mode_control_reg;
	logic                capture_compare_control;
	logic [15:0]         compare_capture_a;
	logic [15:0]         capture_b;
	logic [15:0]         count_register;
	logic                overflow_flag;
	logic                match_flag;
	logic                capture_flag;
	// timer state
	ievt_pkg::ievt_run_t run_state;
	logic [7:0]          prescale;
	// bus state
	logic                aw_held;
	logic [31:0]         aw_addr;
	logic                w_held;
	logic [31:0]         w_data;
	logic [3:0]          w_strb;
	logic                bvalid;
	logic [1:0]          bresp;
	logic                rvalid;
	logic [31:0]         rdata;
	logic [1:0]          rresp;

	logic [7:0]          next_prescaler_mode;
	logic [1:0]          next_mode_control_reg;
	logic                next_capture_compare_control;
	logic [15:0]         next_compare_capture_a;
	logic [15:0]         next_capture_b;
	logic [15:0]         next_count_register;
	logic                next_overflow_flag;
	logic                next_match_flag;
	logic                next_capture_flag;
	ievt_pkg::ievt_run_t next_run_state;
	logic [7:0]          next_prescale;
	logic                next_aw_held;
	logic [31:0]         next_aw_addr;
	logic                next_w_held;
	logic [31:0]         next_w_data;
	logic [3:0]          next_w_strb;
	logic                next_bvalid;
	logic [1:0]          next_bresp;
	logic                next_rvalid;
	logic [31:0]         next_rdata;
	logic [1:0]          next_rresp;
	logic                next_match_irq_a;
	logic                next_capture_irq_b;

	// decode helpers
	logic [1:0]          clock_select;
	logic [1:0]          edge_select_a;
	logic [1:0]          edge_select_b;
	logic                pre_tick;
	logic                sample_a;
	logic                sample_b;
	logic                edge_a;
	logic                edge_b;
	logic                count_tick;
	logic                do_write;
	logic [31:0]         write_word;

	// true when the byte address names a register word
	function automatic logic ievt_reg_hit(input logic [31:0] addr);
		ievt_reg_hit = (addr[31:5] == 27'h0000000) && (addr[4:2] <= 3'h6);
	endfunction : ievt_reg_hit

	// byte-lane merge of a write onto a word
	function automatic logic [31:0] ievt_merge(input logic [31:0] old_word,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] merged;
		merged = old_word;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merged[8*i +: 8] = data[8*i +: 8];
			end
		end
		ievt_merge = merged;
	endfunction : ievt_merge

	// register contents as seen on the bus
	function automatic logic [31:0] ievt_read_word(input logic [4:0] ofs,
		input logic [7:0] pm, input logic [1:0] mc, input logic cc,
		input logic [15:0] ca, input logic [15:0] cb, input logic [15:0] cr,
		input logic [2:0] st);
		unique case (ofs)
			ievt_pkg::OFS_PRESCALER_MODE:  ievt_read_word = {24'h000000, pm};
			ievt_pkg::OFS_MODE_CONTROL:    ievt_read_word = {30'h00000000, mc};
			ievt_pkg::OFS_CAPTURE_CONTROL: ievt_read_word = {31'h00000000, cc};
			ievt_pkg::OFS_COMPARE_CAPTURE: ievt_read_word = {16'h0000, ca};
			ievt_pkg::OFS_CAPTURE_B:       ievt_read_word = {16'h0000, cb};
			ievt_pkg::OFS_COUNT_REGISTER:  ievt_read_word = {16'h0000, cr};
			ievt_pkg::OFS_STATUS:          ievt_read_word = {29'h00000000, st};
			default:                       ievt_read_word = 32'h00000000;
		endcase
	endfunction : ievt_read_word

	function automatic ievt_pkg::ievt_run_t ievt_mode_state(input logic [1:0] mode);
		unique case (mode)
			ievt_pkg::MODE_FREE:  ievt_mode_state = ievt_pkg::RUN_FREE;
			ievt_pkg::MODE_CLEAR: ievt_mode_state = ievt_pkg::RUN_CLEAR;
			default:              ievt_mode_state = ievt_pkg::RUN_STOP;
		endcase
	endfunction : ievt_mode_state

	// field slices and count clock selection
	assign clock_select  = prescaler_mode[ievt_pkg::CLOCK_SELECT_BIT_LOW +: 2];
	assign edge_select_a = prescaler_mode[ievt_pkg::EDGE_SELECT_A_LOW +: 2];
	assign edge_select_b = prescaler_mode[ievt_pkg::EDGE_SELECT_B_LOW +: 2];

	// prescaler taps; the event pin path samples every peripheral clock
	always_comb begin
		unique case (clock_select)
			ievt_pkg::CLK_PERIPH: pre_tick = 1'b1;
			ievt_pkg::CLK_DIV4:   pre_tick = (prescale & ievt_pkg::DIV4_MASK) == ievt_pkg::DIV4_MASK;
			ievt_pkg::CLK_DIV256: pre_tick = prescale == ievt_pkg::DIV256_MASK;
			default:              pre_tick = 1'b1;
		endcase
	end

	assign sample_a   = (run_state != ievt_pkg::RUN_STOP) && pre_tick;
	assign sample_b   = (run_state != ievt_pkg::RUN_STOP) && pre_tick;
	assign count_tick = (clock_select == ievt_pkg::CLK_EVENT_PIN) ? edge_a : pre_tick;

	ievt_edge_filter u_filter_a (
		.clock        (clock),
		.reset        (reset),
		.clock_enable (clock_enable),
		.sample       (sample_a),
		.level        (event_input_a),
		.edge_sel     (edge_select_a),
		.edge_hit     (edge_a)
	);

	ievt_edge_filter u_filter_b (
		.clock        (clock),
		.reset        (reset),
		.clock_enable (clock_enable),
		.sample       (sample_b),
		.level        (capture_input_b),
		.edge_sel     (edge_select_b),
		.edge_hit     (edge_b)
	);

	// bus handshakes; a held address or data stalls its own channel only
	assign axil_rsp.awready = !aw_held && !bvalid;
	assign axil_rsp.wready  = !w_held && !bvalid;
	assign axil_rsp.bvalid  = bvalid;
	assign axil_rsp.bresp   = bresp;
	assign axil_rsp.arready = !rvalid;
	assign axil_rsp.rvalid  = rvalid;
	assign axil_rsp.rdata   = rdata;
	assign axil_rsp.rresp   = rresp;

	assign do_write   = aw_held && w_held && !bvalid;
	assign write_word = ievt_merge(ievt_read_word(aw_addr[4:0], prescaler_mode,
		mode_control_reg, capture_compare_control, compare_capture_a, capture_b,
		count_register, {capture_flag, match_flag, overflow_flag}), w_data, w_strb);

	// next state of bus, registers and counter
	always_comb begin
		next_prescaler_mode          = prescaler_mode;
		next_mode_control_reg        = mode_control_reg;
		next_capture_compare_control = capture_compare_control;
		next_compare_capture_a       = compare_capture_a;
		next_capture_b               = capture_b;
		next_count_register          = count_register;
		next_overflow_flag           = overflow_flag;
		next_match_flag              = match_flag;
		next_capture_flag            = capture_flag;
		next_run_state               = ievt_mode_state(mode_control_reg);
		next_prescale                = prescale + 8'h01;
		next_aw_held                 = aw_held;
		next_aw_addr                 = aw_addr;
		next_w_held                  = w_held;
		next_w_data                  = w_data;
		next_w_strb                  = w_strb;
		next_bvalid                  = bvalid;
		next_bresp                   = bresp;
		next_rvalid                  = rvalid;
		next_rdata                   = rdata;
		next_rresp                   = rresp;
		next_match_irq_a             = 1'b0;
		next_capture_irq_b           = 1'b0;

		// write channels, taken in either order
		if (axil_req.awvalid && !aw_held && !bvalid) begin
			next_aw_held = 1'b1;
			next_aw_addr = axil_req.awaddr;
		end
		if (axil_req.wvalid && !w_held && !bvalid) begin
			next_w_held = 1'b1;
			next_w_data = axil_req.wdata;
			next_w_strb = axil_req.wstrb;
		end
		if (bvalid && axil_req.bready) begin
			next_bvalid = 1'b0;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = ievt_reg_hit(aw_addr) ? ievt_pkg::RESP_OKAY : ievt_pkg::RESP_SLVERR;
			if (ievt_reg_hit(aw_addr)) begin
				unique case (aw_addr[4:0])
					ievt_pkg::OFS_PRESCALER_MODE:  next_prescaler_mode = write_word[7:0];
					ievt_pkg::OFS_MODE_CONTROL:    next_mode_control_reg = write_word[1:0];
					ievt_pkg::OFS_CAPTURE_CONTROL: next_capture_compare_control = write_word[0];
					ievt_pkg::OFS_COMPARE_CAPTURE: next_compare_capture_a = write_word[15:0];
					ievt_pkg::OFS_STATUS: begin
						// write one to clear; a same-cycle event below wins
						if (w_strb[0] && w_data[ievt_pkg::STATUS_OVERFLOW_BIT]) next_overflow_flag = 1'b0;
						if (w_strb[0] && w_data[ievt_pkg::STATUS_MATCH_BIT])    next_match_flag = 1'b0;
						if (w_strb[0] && w_data[ievt_pkg::STATUS_CAPTURE_BIT])  next_capture_flag = 1'b0;
					end
					default: ; // capture_b and count_register are read-only
				endcase
			end
		end

		// read channel
		if (rvalid && axil_req.rready) begin
			next_rvalid = 1'b0;
		end
		if (axil_req.arvalid && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp  = ievt_reg_hit(axil_req.araddr) ? ievt_pkg::RESP_OKAY : ievt_pkg::RESP_SLVERR;
			// an unmapped word must not alias onto a register through the low bits
			next_rdata  = 32'h00000000;
			if (ievt_reg_hit(axil_req.araddr)) begin
				next_rdata = ievt_read_word(axil_req.araddr[4:0], prescaler_mode,
					mode_control_reg, capture_compare_control, compare_capture_a, capture_b,
					count_register, {capture_flag, match_flag, overflow_flag});
			end
		end

		// counter; stopping clears it so a restart begins at zero
		unique case (run_state)
			ievt_pkg::RUN_STOP: begin
				next_count_register = ievt_pkg::COUNT_RESET;
				next_prescale       = 8'h00;
			end
			ievt_pkg::RUN_CLEAR: begin
				if (count_tick) begin
					if (count_register == compare_capture_a) begin
						next_count_register = ievt_pkg::COUNT_RESET;
						next_match_irq_a    = 1'b1;
						next_match_flag     = 1'b1;
						if (compare_capture_a == ievt_pkg::COUNT_MAX) next_overflow_flag = 1'b1;
					end else begin
						// a compare below the count is only met after the wrap
						next_count_register = count_register + 16'h0001;
						if (count_register == ievt_pkg::COUNT_MAX) next_overflow_flag = 1'b1;
					end
				end
			end
			ievt_pkg::RUN_FREE: begin
				if (count_tick) begin
					next_count_register = count_register + 16'h0001;
					if (count_register == ievt_pkg::COUNT_MAX) next_overflow_flag = 1'b1;
				end
				// captures need the prescaled clock; event-pin counting disables them
				if (clock_select != ievt_pkg::CLK_EVENT_PIN) begin
					if (edge_a) begin
						next_capture_b     = count_register;
						next_capture_irq_b = 1'b1;
						next_capture_flag  = 1'b1;
					end
					if (edge_b && capture_compare_control) begin
						next_compare_capture_a = count_register;
						next_match_irq_a       = 1'b1;
						next_match_flag        = 1'b1;
					end
				end
			end
			default: begin
				next_count_register = ievt_pkg::COUNT_RESET;
				next_prescale       = 8'h00;
			end
		endcase
	end

	// all state freezes while the clock enable is low
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			prescaler_mode          <= ievt_pkg::PRESCALER_MODE_RESET;
			mode_control_reg        <= ievt_pkg::MODE_CONTROL_RESET;
			capture_compare_control <= ievt_pkg::CAPTURE_CONTROL_RESET;
			compare_capture_a       <= ievt_pkg::COMPARE_CAPTURE_RESET;
			capture_b               <= ievt_pkg::CAPTURE_B_RESET;
			count_register          <= ievt_pkg::COUNT_RESET;
			overflow_flag           <= 1'b0;
			match_flag              <= 1'b0;
			capture_flag            <= 1'b0;
			run_state               <= ievt_pkg::RUN_STOP;
			prescale                <= 8'h00;
			aw_held                 <= 1'b0;
			aw_addr                 <= 32'h00000000;
			w_held                  <= 1'b0;
			w_data                  <= 32'h00000000;
			w_strb                  <= 4'h0;
			bvalid                  <= 1'b0;
			bresp                   <= ievt_pkg::RESP_OKAY;
			rvalid                  <= 1'b0;
			rdata                   <= 32'h00000000;
			rresp                   <= ievt_pkg::RESP_OKAY;
			match_irq_a             <= 1'b0;
			capture_irq_b           <= 1'b0;
		end else if (clock_enable) begin
			prescaler_mode          <= next_prescaler_mode;
			mode_control_reg        <= next_mode_control_reg;
			capture_compare_control <= next_capture_compare_control;
			compare_capture_a       <= next_compare_capture_a;
			capture_b               <= next_capture_b;
			count_register          <= next_count_register;
			overflow_flag           <= next_overflow_flag;
			match_flag              <= next_match_flag;
			capture_flag            <= next_capture_flag;
			run_state               <= next_run_state;
			prescale                <= next_prescale;
			aw_held                 <= next_aw_held;
			aw_addr                 <= next_aw_addr;
			w_held                  <= next_w_held;
			w_data                  <= next_w_data;
			w_strb                  <= next_w_strb;
			bvalid                  <= next_bvalid;
			bresp                   <= next_bresp;
			rvalid                  <= next_rvalid;
			rdata                   <= next_rdata;
			rresp                   <= next_rresp;
			match_irq_a             <= next_match_irq_a;
			capture_irq_b           <= next_capture_irq_b;
		end
	end

endmodule : ievt_timer

// ==== ievt_timer_properties.sv ====
`timescale 1ns/1ps

// pin-level checks on the timer; it sees only the top ports
module ievt_timer_properties (
	// clock and reset
	input wire logic                     clock,
	input wire logic                     reset,
	input wire logic                     clock_enable,
	// register bus
	input wire ievt_pkg::ievt_axil_req_t axil_req,
	input wire ievt_pkg::ievt_axil_rsp_t axil_rsp,
	// pins and events
	input wire logic                     event_input_a,
	input wire logic                     capture_input_b,
	input wire logic                     match_irq_a,
	input wire logic                     capture_irq_b
);
	default clocking dc @(posedge clock); endclocking
	default disable iff (reset);

	// answers stand, payload frozen, until the master takes them
	chk_bresp_stands: assert property (
		axil_rsp.bvalid && !axil_req.bready |=> axil_rsp.bvalid && $stable(axil_rsp.bresp))
		else $error("write answer dropped early");
	chk_rdata_stands: assert property (
		axil_rsp.rvalid && !axil_req.rready |=> axil_rsp.rvalid && $stable(axil_rsp.rdata))
		else $error("read answer dropped early");
	// a pending answer blocks new requests
	chk_write_blocks: assert property (
		axil_rsp.bvalid |-> !axil_rsp.awready && !axil_rsp.wready)
		else $error("write taken while answer pending");
	chk_read_blocks: assert property (
		axil_rsp.rvalid |-> !axil_rsp.arready)
		else $error("read taken while answer pending");
	// answers come within the promised latency
	chk_read_answer: assert property (
		axil_req.arvalid && axil_rsp.arready && clock_enable |-> ##[1:2] axil_rsp.rvalid)
		else $error("read answer late");
	chk_write_answer: assert property (
		axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready
		&& clock_enable |-> ##[1:3] axil_rsp.bvalid)
		else $error("write answer late");
	chk_unmapped_read: assert property (
		axil_req.arvalid && axil_rsp.arready && clock_enable && axil_req.araddr[31:2] > 30'h6
		|-> ##[1:2] (axil_rsp.rvalid && axil_rsp.rresp == ievt_pkg::RESP_SLVERR
		&& axil_rsp.rdata == 32'h0))
		else $error("unmapped read not refused");
	// the filter needs two samples per level, so filter events never come back to back; clear-mode matches at compare 0 on the peripheral clock do
	chk_capture_pulse: assert property (
		capture_irq_b && clock_enable |=> !capture_irq_b)
		else $error("capture event longer than one cycle");
	chk_match_pulse: assert property (
		match_irq_a && clock_enable |=> !match_irq_a)
		else $error("match event longer than one cycle");

	cover property (capture_irq_b);
	cover property (match_irq_a);
	cover property (axil_rsp.rvalid && axil_rsp.rresp == ievt_pkg::RESP_SLVERR);
endmodule : ievt_timer_properties

bind ievt_timer ievt_timer_properties ievt_timer_properties_inst (.clock, .reset, .clock_enable,
	.axil_req, .axil_rsp, .event_input_a, .capture_input_b, .match_irq_a, .capture_irq_b);

// ==== ievt_pulse_source.sv ====
`timescale 1ns/1ps

// far-side signal sources; pins are always driven, never left floating
module ievt_pulse_source (
	// clock
	input wire logic clock,
	// driven pins
	output logic     event_input_a,
	output logic     capture_input_b
);
	initial begin
		event_input_a = 1'b0;
		capture_input_b = 1'b0;
	end

	// sets one pin just after an edge, then holds it for hold clocks
	task automatic drive(input logic pin_b, input logic lvl, input int hold);
		@(posedge clock);
		if (pin_b)
			capture_input_b <= lvl;
		else
			event_input_a <= lvl;
		repeat (hold) @(posedge clock);
	endtask : drive
endmodule : ievt_pulse_source

// ==== tb_interval_event_pulse_timer.sv ====
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end

module tb_interval_event_pulse_timer;
	logic                     clock;
	logic                     reset;
	logic                     clock_enable;
	ievt_pkg::ievt_axil_req_t req;
	ievt_pkg::ievt_axil_rsp_t rsp;
	logic                     event_input_a;
	logic                     capture_input_b;
	logic                     match_irq_a;
	logic                     capture_irq_b;
	logic [31:0]              rd;
	logic [1:0]               rr;
	int                       fails;
	int                       compares;
	int                       cap_pulses;

	ievt_timer ievt_timer_inst (.clock, .reset, .clock_enable, .axil_req(req),
		.axil_rsp(rsp), .event_input_a, .capture_input_b, .match_irq_a, .capture_irq_b);
	ievt_pulse_source ievt_pulse_source_inst (.clock, .event_input_a, .capture_input_b);

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// capture events counted mid-cycle, where the pulse is settled
	always @(negedge clock) begin
		if (capture_irq_b) cap_pulses++;
	end

	task automatic give_verdict;
		if (fails == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// readies sampled mid-cycle are what the next rising edge sees
	task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
		logic aw;
		logic w;
		logic ta;
		logic tw;
		int   n;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		@(posedge clock);
		req.awaddr <= {27'h0, a};
		req.wdata <= d;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		while (aw || w) begin
			@(negedge clock);
			ta = aw && rsp.awready;
			tw = w && rsp.wready;
			@(posedge clock);
			if (ta) begin
				req.awvalid <= 1'b0;
				aw = 1'b0;
			end
			if (tw) begin
				req.wvalid <= 1'b0;
				w = 1'b0;
			end
		end
		// bready raised late on purpose so the answer must stand
		do begin @(negedge clock); n++; end while (!rsp.bvalid && n < 2000);
		if (n >= 2000) fails++;
		@(posedge clock);
		req.bready <= 1'b1;
		@(posedge clock);
		req.bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [4:0] a);
		int n;
		n = 0;
		@(posedge clock);
		req.araddr <= {27'h0, a};
		req.arvalid <= 1'b1;
		do begin @(negedge clock); n++; end while (!rsp.arready && n < 2000);
		@(posedge clock);
		req.arvalid <= 1'b0;
		do begin @(negedge clock); n++; end while (!rsp.rvalid && n < 4000);
		if (n >= 4000) fails++;
		rd = rsp.rdata;
		rr = rsp.rresp;
		@(posedge clock);
		req.rready <= 1'b1;
		@(posedge clock);
		req.rready <= 1'b0;
	endtask : axi_read

	// stop, then control, clock, compare, clear status, start
	task automatic arm(input logic [7:0] pm, input logic cc, input logic [15:0] n,
		input logic [1:0] md);
		axi_write(ievt_pkg::OFS_MODE_CONTROL, {30'h0, ievt_pkg::MODE_STOP});
		axi_write(ievt_pkg::OFS_CAPTURE_CONTROL, {31'h0, cc});
		axi_write(ievt_pkg::OFS_PRESCALER_MODE, {24'h0, pm});
		axi_write(ievt_pkg::OFS_COMPARE_CAPTURE, {16'h0, n});
		axi_write(ievt_pkg::OFS_STATUS, 32'h7);
		axi_write(ievt_pkg::OFS_MODE_CONTROL, {30'h0, md});
	endtask : arm

	// cycles from one match event to the next, bounded
	task automatic period(output int p);
		int n;
		n = 0;
		do begin @(negedge clock); n++; end while (!match_irq_a && n < 70000);
		p = 0;
		do begin @(negedge clock); p++; end while (!match_irq_a && p < 70000);
	endtask : period

	task automatic t_reset;
		axi_read(ievt_pkg::OFS_PRESCALER_MODE);
		`CHK(rd[7:0], ievt_pkg::PRESCALER_MODE_RESET);
		axi_read(ievt_pkg::OFS_COMPARE_CAPTURE);
		`CHK(rd[15:0], ievt_pkg::COMPARE_CAPTURE_RESET);
		axi_write(ievt_pkg::OFS_COUNT_REGISTER, 32'h55);
		axi_read(ievt_pkg::OFS_COUNT_REGISTER);
		`CHK(rd[15:0], ievt_pkg::COUNT_RESET);
		axi_read(5'h1C);
		`CHK(rr, ievt_pkg::RESP_SLVERR);
	endtask : t_reset

	// each prescaled count clock choice (periph, div 4, div 256) with its expected match period; the event pin choice is not run
	task automatic t_interval;
		logic [1:0]  sel [3] = '{2'h0, 2'h1, 2'h2};
		logic [15:0] cmp [3] = '{16'h0005, 16'h0002, 16'h0001};
		int          exp [3] = '{6, 12, 512};
		int          p;
		for (int i = 0; i < 3; i++) begin
			arm({6'h0, sel[i]}, 1'b0, cmp[i], ievt_pkg::MODE_CLEAR);
			period(p);
			`CHK(p, exp[i]);
			axi_read(ievt_pkg::OFS_STATUS);
			`CHK(rd[0], 1'b0);
		end
	endtask : t_interval

	task automatic t_overflow;
		int n;
		n = 0;
		arm(8'h00, 1'b0, ievt_pkg::COUNT_MAX, ievt_pkg::MODE_CLEAR);
		do begin @(negedge clock); n++; end while (!match_irq_a && n < 70000);
		axi_read(ievt_pkg::OFS_STATUS);
		`CHK(rd[0], 1'b1);
	endtask : t_overflow

	// glitch first, then two whole pulses per edge code; compare value is 3
	task automatic t_event;
		logic [1:0] code [4] = '{2'h1, 2'h0, 2'h3, 2'h2};
		logic [15:0] cnt [4] = '{16'h0002, 16'h0002, 16'h0000, 16'h0000};
		logic        hit [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			arm({2'h0, code[i], 4'h3}, 1'b0, 16'h0003, ievt_pkg::MODE_CLEAR);
			ievt_pulse_source_inst.drive(1'b0, 1'b1, 0);
			ievt_pulse_source_inst.drive(1'b0, 1'b0, 4);
			repeat (2) begin
				ievt_pulse_source_inst.drive(1'b0, 1'b1, 4);
				ievt_pulse_source_inst.drive(1'b0, 1'b0, 4);
			end
			repeat (4) @(posedge clock);
			axi_read(ievt_pkg::OFS_COUNT_REGISTER);
			`CHK(rd[15:0], cnt[i]);
			axi_read(ievt_pkg::OFS_STATUS);
			`CHK(rd[1], hit[i]);
		end
	endtask : t_event

	// both pins on both edges; last edges 11 clocks apart
	task automatic t_capture;
		logic [15:0] ca;
		arm(8'hF0, 1'b1, 16'h0000, ievt_pkg::MODE_FREE);
		cap_pulses = 0;
		ievt_pulse_source_inst.drive(1'b0, 1'b1, 10);
		ievt_pulse_source_inst.drive(1'b1, 1'b1, 10);
		ievt_pulse_source_inst.drive(1'b0, 1'b0, 10);
		ievt_pulse_source_inst.drive(1'b1, 1'b0, 10);
		repeat (6) @(posedge clock);
		axi_read(ievt_pkg::OFS_CAPTURE_B);
		ca = rd[15:0];
		axi_read(ievt_pkg::OFS_COMPARE_CAPTURE);
		`CHK(rd[15:0] - ca, 16'h000B);
		axi_read(ievt_pkg::OFS_STATUS);
		`CHK(rd[2:1], 2'h3);
		`CHK(cap_pulses, 2);
	endtask : t_capture

	// a frozen span adds nothing; only the one live edge before it counts
	task automatic t_freeze;
		logic [15:0] a;
		logic [15:0] b;
		axi_read(ievt_pkg::OFS_COUNT_REGISTER);
		a = rd[15:0];
		axi_read(ievt_pkg::OFS_COUNT_REGISTER);
		b = rd[15:0] - a;
		axi_read(ievt_pkg::OFS_COUNT_REGISTER);
		a = rd[15:0];
		@(posedge clock);
		clock_enable <= 1'b0;
		repeat (100) @(posedge clock);
		clock_enable <= 1'b1;
		axi_read(ievt_pkg::OFS_COUNT_REGISTER);
		`CHK(rd[15:0] - a, b + 16'h0001);
	endtask : t_freeze

	initial begin
		fails = 0;
		compares = 0;
		reset = 1'b1;
		clock_enable = 1'b1;
		cap_pulses = 0;
		req = '0;
		req.wstrb = 4'hF;
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		t_reset;
		t_interval;
		t_overflow;
		t_event;
		t_capture;
		t_freeze;
		give_verdict;
	end

	// about 70k clocks expected; 100k means a hang
	initial begin
		#2500000;
		fails++;
		give_verdict;
	end
endmodule : tb_interval_event_pulse_timer
